// *** adc_ctl_pkg.sv ***
// Constants shared by the sigma-delta converter control registers.
// Assumes a 32-bit AXI4-Lite register bus and a modulator bitstream input.
package adc_ctl_pkg;

  // Register byte offsets
  localparam logic [19:0] OFF_RUN    = 20'h4_1100;
  localparam logic [19:0] OFF_CFG    = 20'h4_1104;
  localparam logic [19:0] OFF_RESULT = 20'h4_1108;
  localparam logic [19:0] OFF_IRQ_ST = 20'h4_110C;
  localparam logic [19:0] OFF_IRQ_EN = 20'h4_1110;
  localparam logic [19:0] OFF_IRQ_CL = 20'h4_1114;

  // Run control fields
  localparam int RUN_EN_BIT    = 0;
  localparam int RUN_CF_BIT    = 1;
  localparam int RUN_OSR_LSB   = 2;
  localparam int RUN_FAST_BIT  = 6;
  localparam int RUN_NREF_LSB  = 16;
  localparam int RUN_PREF_LSB  = 18;
  localparam int RUN_RSHR_BIT  = 20;
  localparam int RUN_ISHR_BIT  = 21;
  localparam logic [31:0] RUN_MASK = 32'h003F_007F;

  // Gain and input config fields
  localparam int CFG_NIN_LSB   = 0;
  localparam int CFG_PIN_LSB   = 4;
  localparam int CFG_FGAIN_LSB = 16;
  localparam int CFG_HALF_BIT  = 19;
  localparam int CFG_SGAIN_LSB = 20;
  localparam int CFG_ZOFF_LSB  = 24;
  localparam logic [31:0] CFG_MASK = 32'h0F3F_00FF;

  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  // Oversampling and chopper figures
  localparam logic [3:0] OSR_MAX_CODE  = 4'hA;
  localparam int         OSR_BASE_LOG2 = 15;
  localparam int         CHOP_SLOW_DIV = 128;
  localparam int         CHOP_FAST_DIV = 32;
  localparam int         DISCARD_CNT   = 2;
  localparam int         CLK_HZ        = 20_000_000;
  localparam int         CONV_CLK_HZ   = 327_680;
  localparam int         CONV_DIV      = CLK_HZ / CONV_CLK_HZ;

  // Response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : adc_ctl_pkg

// *** adc_chan_if.sv ***
`timescale 1ns/1ps
// Carries filter control and results between the register block and filter.
// Assumes both ends run on the register bus clock.
interface adc_chan_if;
  logic        run;
  logic [3:0]  osr_code;
  logic        mod_bit;
  logic        conv_tick;
  logic        res_valid;
  logic [23:0] res_data;
  modport ctl  (output run, osr_code, mod_bit, conv_tick,
                input  res_valid, res_data);
  modport filt (input  run, osr_code, mod_bit, conv_tick,
                output res_valid, res_data);
endinterface : adc_chan_if

// *** adc_decimator.sv ***
`timescale 1ns/1ps
// Decimation filter for the modulator bitstream.
// Assumes a one-cycle conversion tick and a synchronised modulator bit.
module adc_decimator
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Channel
  adc_chan_if.filt  ch
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [31:0] acc;
    logic [1:0]  drop;
    logic        valid;
    logic [23:0] data;
  } dec_s;

  dec_s st_r;
  dec_s st_nxt;
  logic [3:0]  code;
  logic [15:0] last;
  logic [31:0] sum;

  always_comb begin
    code = (ch.osr_code > OSR_MAX_CODE) ? 4'h0 : ch.osr_code;
    last = 16'((32'd1 << (OSR_BASE_LOG2 - int'(code))) - 32'd1);
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    sum          = st_r.acc + (ch.mod_bit ? 32'd1 : 32'd0);
    if (!ch.run) begin
      st_nxt = '0;
    end else if (ch.conv_tick) begin
      st_nxt.acc = sum;
      st_nxt.cnt = st_r.cnt + 16'd1;
      if (st_r.cnt == last) begin
        st_nxt.cnt = '0;
        st_nxt.acc = '0;
        if (st_r.drop != 2'(DISCARD_CNT)) begin
          st_nxt.drop = st_r.drop + 2'd1;
        end else begin
          st_nxt.valid = 1'b1;
          st_nxt.data  = 24'((sum << (24 - OSR_BASE_LOG2 + int'(code)))
                             - 32'h0080_0000);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign ch.res_valid = st_r.valid & ce;
  assign ch.res_data  = st_r.data;

endmodule : adc_decimator

// *** adc_ctl_top.sv ***
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Register block of the sigma-delta converter, AXI4-Lite slave.
// Assumes a modulator bitstream from the analogue side on aclk's rate.
// What this block does
// - Normal chopper runs converter clock over 128
// - Fast chopper runs converter clock over 32
// - Code zero is 32768, each halves ratio
// - Code 1010 selects ratio 32
// - Word rate is converter clock over ratio
// - Comb bit zero holds filter in reset
// - First two filter outputs are discarded
// - Each new result raises converter interrupt while the run enable bit is set
// - Zero offset field passes to analogue side
// - Second gain field selects 1, 2, 4
// - Reference bit selects full or half
// - Front gain selects 1, 8, 16, 32
// - Positive selector routes listed sources
// - Negative selector routes listed sources
// - Positive reference selector picks source
// - Result read-only, 24 bits high, low zero
module adc_ctl_top
  import adc_ctl_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Modulator side
  input  wire logic              mod_bit_in,
  output logic                   chopper_clk,
  output logic                   converter_clock,
  output logic                   converter_enable,
  output logic [31:0]            analog_cfg,
  output logic [5:0]             analog_route,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    logic        awr;
    logic [ADDR_W-1:0] awa;
    logic        wr;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic        arr;
    logic [31:0] run;
    logic [31:0] cfg;
    logic [23:0] result;
    logic        st;
    logic        en;
    logic        irq;
    logic [7:0]  div;
    logic        cck;
    logic [6:0]  chop;
    logic        chk;
    logic        tick;
    logic        s1;
    logic        s2;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  adc_chan_if ch ();

  adc_decimator u_dec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .ch      (ch.filt)
  );

  assign ch.run      = st_r.run[RUN_CF_BIT];
  assign ch.osr_code = st_r.run[RUN_OSR_LSB +: 4];
  assign ch.mod_bit  = st_r.s2;
  assign ch.conv_tick = st_r.tick;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be,
                                        input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r & msk;
  endfunction : merge

  logic            do_wr;
  logic            do_rd;
  logic            hit_w;
  logic            hit_r;
  logic [31:0]     rdv;
  logic [6:0]      chop_last;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.s1   = mod_bit_in;
    st_nxt.s2   = st_r.s1;

    // Converter clock divider
    if (st_r.div == 8'(CONV_DIV - 1)) begin
      st_nxt.div  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 8'd1;
    end
    if (st_r.div == 8'(CONV_DIV / 2 - 1) || st_r.div == 8'(CONV_DIV - 1)) begin
      st_nxt.cck = ~st_r.cck;
    end

    chop_last = 7'(CHOP_SLOW_DIV / 2 - 1);
    if (st_r.run[RUN_FAST_BIT]) begin
      chop_last = 7'(CHOP_FAST_DIV / 2 - 1);
    end
    if (st_r.tick) begin
      if (st_r.chop >= chop_last) begin
        st_nxt.chop = '0;
        st_nxt.chk  = ~st_r.chk;
      end else begin
        st_nxt.chop = st_r.chop + 7'd1;
      end
    end

    // Write channel capture
    if (s_axi_awvalid && st_r.awr) begin
      st_nxt.awr = 1'b0;
      st_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wr) begin
      st_nxt.wr = 1'b0;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    do_wr = !st_r.awr && !st_r.wr && !st_r.bv;
    hit_w = 1'b1;
    if (do_wr) begin
      unique case (st_r.awa[19:0])
        OFF_RUN: st_nxt.run = merge(st_r.run, st_r.wd, st_r.ws, RUN_MASK);
        OFF_CFG: st_nxt.cfg = merge(st_r.cfg, st_r.wd, st_r.ws, CFG_MASK);
        OFF_IRQ_EN: st_nxt.en = st_r.ws[0] ? st_r.wd[0] : st_r.en;
        OFF_IRQ_CL: begin
          if (st_r.ws[0] && st_r.wd[0]) begin
            st_nxt.st = 1'b0;
          end
        end
        OFF_RESULT, OFF_IRQ_ST: hit_w = 1'b1;
        default: hit_w = 1'b0;
      endcase
      st_nxt.bv = 1'b1;
      st_nxt.br = hit_w ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bv && s_axi_bready) begin
      st_nxt.bv  = 1'b0;
      st_nxt.awr = 1'b1;
      st_nxt.wr  = 1'b1;
    end

    // New result, set wins over clear
    if (ch.res_valid) begin
      st_nxt.result = ch.res_data;
      if (st_r.run[RUN_EN_BIT]) begin
        st_nxt.st = 1'b1;
      end
    end
    st_nxt.irq = st_nxt.st & st_nxt.en;

    // Read channel
    do_rd = s_axi_arvalid && !st_r.rv;
    hit_r = 1'b1;
    unique case (s_axi_araddr[19:0])
      OFF_RUN:    rdv = st_r.run;
      OFF_CFG:    rdv = st_r.cfg;
      OFF_RESULT: rdv = {st_r.result, 8'h00};
      OFF_IRQ_ST: rdv = {31'h0000_0000, st_r.st};
      OFF_IRQ_EN: rdv = {31'h0000_0000, st_r.en};
      OFF_IRQ_CL: rdv = RESET_VAL;
      default: begin
        rdv   = RESET_VAL;
        hit_r = 1'b0;
      end
    endcase
    if (do_rd) begin
      st_nxt.rv = 1'b1;
      st_nxt.rd = rdv;
      st_nxt.rr = hit_r ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rv && s_axi_rready) begin
      st_nxt.rv = 1'b0;
    end
    st_nxt.arr = !st_nxt.rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r     <= '0;
      st_r.awr <= 1'b1;
      st_r.wr  <= 1'b1;
      st_r.arr <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready    = st_r.awr;
  assign s_axi_wready     = st_r.wr;
  assign s_axi_bvalid     = st_r.bv;
  assign s_axi_bresp      = st_r.br;
  assign s_axi_arready    = st_r.arr;
  assign s_axi_rvalid     = st_r.rv;
  assign s_axi_rdata      = st_r.rd;
  assign s_axi_rresp      = st_r.rr;
  assign chopper_clk      = st_r.chk;
  assign converter_clock  = st_r.cck;
  assign converter_enable = st_r.run[RUN_EN_BIT];
  assign analog_cfg       = st_r.cfg;
  assign analog_route     = st_r.run[RUN_ISHR_BIT:RUN_NREF_LSB];
  assign irq              = st_r.irq;

endmodule : adc_ctl_top

// *** adc_ctl_sva.sv ***
// Checker for the converter register block.
// Assumes whole-word writes with address and data offered together.
`timescale 1ns/1ps
module adc_ctl_sva
  import adc_ctl_pkg::*;
#(parameter int ADDR_W = 20) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Converter side
  input wire logic              converter_clock,
  input wire logic              converter_enable,
  input wire logic [31:0]       analog_cfg,
  input wire logic [5:0]        analog_route,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic              rd_res;
  logic              cq;
  logic              seen;
  int                cc;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa <= s_axi_awaddr;
      wd <= s_axi_wdata;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_res <= (s_axi_araddr == OFF_RESULT);
    end
    cq <= converter_clock;
    cc <= (converter_clock && !cq) ? 0 : cc + 1;
    seen <= aresetn && ce && (seen || (converter_clock && !cq));
  end
  property p_irq_en; $rose(irq) |-> $past(converter_enable); endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
  property p_res_low; s_axi_rvalid && rd_res |-> s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_res_low: assert property (p_res_low) else $error("result low byte");
  property p_res_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_res_hold: assert property (p_res_hold) else $error("read not held");
  property p_cfg_upd; $rose(s_axi_bvalid) && wa == OFF_CFG |->
    analog_cfg == (wd & CFG_MASK); endproperty
  a_cfg_upd: assert property (p_cfg_upd) else $error("config port");
  property p_cfg_only; $changed(analog_cfg) |->
    s_axi_bvalid && wa == OFF_CFG; endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("config moved");
  property p_run_upd; $rose(s_axi_bvalid) && wa == OFF_RUN |->
    analog_route == wd[21:16] && converter_enable == wd[0]; endproperty
  a_run_upd: assert property (p_run_upd) else $error("route port");
  property p_run_only; $changed(converter_enable) |->
    s_axi_bvalid && wa == OFF_RUN; endproperty
  a_run_only: assert property (p_run_only) else $error("enable moved");
  property p_conv; converter_clock && !cq && seen |-> cc == CONV_DIV - 1;
  endproperty
  a_conv: assert property (p_conv) else $error("converter period");
  cover property ($rose(irq));
  cover property (s_axi_rvalid && rd_res);
  cover property ($rose(converter_enable));
endmodule : adc_ctl_sva

bind adc_ctl_top adc_ctl_sva #(.ADDR_W(ADDR_W)) i_adc_ctl_sva (
  .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .converter_clock, .converter_enable, .analog_cfg, .analog_route, .irq);

// *** modulator_model.sv ***
// Behavioural modulator: a new bit on each converter clock rise.
// Assumes converter_clock is made by the block on aclk.
`timescale 1ns/1ps
module modulator_model (
  // Clock
  input  wire logic aclk,
  input  wire logic converter_clock,
  // Bitstream
  output logic      mod_bit
);
  logic last_r = 1'h0;
  logic bit_r  = 1'h0;
  assign mod_bit = bit_r;
  always @(posedge aclk) begin
    last_r <= converter_clock;
    if (converter_clock && !last_r) begin
      bit_r <= ~bit_r;
    end
  end
endmodule : modulator_model

// *** testbench.sv ***
// Self-checking bench for the converter register block.
// Assumes the modulator model on the far side.
`timescale 1ns/1ps
module testbench;
  import adc_ctl_pkg::*;
  localparam int P = 32 * CONV_DIV;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [19:0] awaddr = '0;
  logic [19:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        ce = 1'h1;
  logic        awready, wready, bvalid, arready, rvalid, mod_bit;
  logic        chopper_clk, converter_clock, converter_enable, irq;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [31:0] rdata, rd, analog_cfg;
  logic [5:0]  analog_route;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;
  int          t0;
  adc_ctl_top i_adc_ctl_top (
    .aclk, .aresetn, .ce,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mod_bit_in(mod_bit),
    .chopper_clk, .converter_clock, .converter_enable, .analog_cfg,
    .analog_route, .irq);
  modulator_model i_modulator_model (.aclk, .converter_clock, .mod_bit);
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, g);
    compares = compares + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bs = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [19:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rdr
  task automatic wait_irq;
    do @(posedge aclk); while (irq !== 1'h1);
  endtask : wait_irq
  task automatic wait_chop;
    logic c;
    c = chopper_clk;
    do @(posedge aclk); while (chopper_clk === c);
  endtask : wait_chop
  task automatic t_regs;
    rdr(OFF_RUN);
    chk("run reset", RESET_VAL, rd);
    chk("read resp", RESP_OKAY, rs);
    rdr(20'h4_1118);
    chk("unmapped resp", RESP_SLVERR, rs);
    wr(20'h4_1118, 32'h0);
    chk("unmapped wresp", RESP_SLVERR, bs);
    wr(OFF_RESULT, 32'hFFFF_FFFF);
    rdr(OFF_RESULT);
    chk("result read-only", 32'h0, rd);
    wr(OFF_CFG, 32'hFFFF_FFFF);
    chk("write resp", RESP_OKAY, bs);
    rdr(OFF_CFG);
    chk("config", CFG_MASK, rd);
    chk("config port", CFG_MASK, analog_cfg);
    wr(OFF_RUN, 32'hFFFF_FF80);
    rdr(OFF_RUN);
    chk("run", RUN_MASK & 32'hFFFF_FF80, rd);
    chk("route port", 6'h3F, analog_route);
    $display("test regs done");
  endtask : t_regs
  task automatic t_chop;
    for (int f = 0; f < 2; f++) begin
      wr(OFF_RUN, 32'h3 | (f << RUN_FAST_BIT));
      wait_chop;
      t0 = cyc;
      wait_chop;
      chk("chopper half", (f ? 16 : 64) * CONV_DIV, cyc - t0);
    end
    wr(OFF_RUN, 32'h1 | (32'hA << RUN_OSR_LSB));
    wr(OFF_IRQ_CL, 32'h1);
    repeat (3 * P) @(posedge aclk);
    rdr(OFF_IRQ_ST);
    chk("held filter", 32'h0, rd);
    $display("test chop done");
  endtask : t_chop
  task automatic t_rate;
    int p;
    wr(OFF_IRQ_EN, 32'h1);
    for (int k = 9; k < 11; k++) begin
      p = (1 << (OSR_BASE_LOG2 - k)) * CONV_DIV;
      wr(OFF_RUN, 32'h0);
      wr(OFF_IRQ_CL, 32'h1);
      wr(OFF_RUN, 32'h3 | (k << RUN_OSR_LSB));
      t0 = cyc;
      wait_irq;
      chk("first result", 1, cyc - t0 > 2 * p && cyc - t0 <= 4 * p);
      t0 = cyc;
      rdr(OFF_RESULT);
      chk("result low", 32'h0, rd & 32'hFF);
      chk("result mid", 32'h0, rd);
      wr(OFF_IRQ_CL, 32'h1);
      wait_irq;
      chk("result period", p, cyc - t0);
    end
    wr(OFF_IRQ_EN, 32'h0);
    repeat (2 * P) @(posedge aclk);
    chk("masked irq", 1'h0, irq);
    rdr(OFF_IRQ_ST);
    chk("status", 32'h1, rd);
    wr(OFF_RUN, 32'h0);
    wr(OFF_RUN, 32'h3 | (32'hB << RUN_OSR_LSB));
    wr(OFF_IRQ_CL, 32'h1);
    repeat (4 * P) @(posedge aclk);
    rdr(OFF_IRQ_ST);
    chk("reserved ratio", 32'h0, rd);
    $display("test rate done");
  endtask : t_rate
  task automatic t_freeze;
    logic c;
    int   n;
    n = 0;
    ce <= 1'h0;
    @(posedge aclk);
    c = converter_clock;
    repeat (100) begin
      @(posedge aclk);
      if (converter_clock !== c) n = n + 1;
    end
    ce <= 1'h1;
    chk("frozen edges", 0, n);
    $display("test freeze done");
  endtask : t_freeze
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_chop();
    t_freeze();
    t_rate();
    print_verdict();
  end
endmodule : testbench
